// ### hw/gated_timer.sv
/*
 * gated sixteen-bit timer/counter with prescaler, gate selection and overflow interrupt,
 * reached as an ahb-lite slave. assumes a single clk domain; pins arrive asynchronous.
 */
// Local design decisions: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module gated_timer (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        external_clock_pin,
   input  wire logic        temp_osc_clk,
   input  wire logic        gate_input,
   input  wire logic        timer0_overflow,
   input  wire logic        comp1_out,
   input  wire logic        comp2_out,
   input  wire logic        sleep_mode,
   output logic      [15:0] time_base,
   output logic             wake_req,
   output logic             irq
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: stage one read only by stage two
   logic [4:0] pin_s1_r;
   logic [4:0] pin_s2_r;
   logic [4:0] pin_raw;
   assign pin_raw = {comp2_out, comp1_out, gate_input, temp_osc_clk, external_clock_pin};

   always_ff @(posedge clk) begin
      if (rst) begin
         pin_s1_r <= 5'h00;
         pin_s2_r <= 5'h00;
      end else begin
         pin_s1_r <= pin_raw;
         pin_s2_r <= pin_s1_r;
      end
   end

   // extra stage for edge detection of the synchronised external clock and temperature oscillator
   logic       ext_sync_d_r;
   logic       temp_d_r;
   always_ff @(posedge clk) begin
      if (rst) begin
         ext_sync_d_r <= 1'b0;
         temp_d_r     <= 1'b0;
      end else begin
         ext_sync_d_r <= pin_s2_r[0];
         temp_d_r     <= pin_s2_r[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus slave
   logic [7:0]  timer_ctrl_r;
   logic [7:0]  timer_ctrl_nxt;
   logic [7:0]  gate_ctrl_r;
   logic [7:0]  gate_ctrl_nxt;
   logic        stat_r;
   logic        stat_nxt;
   logic        mask_r;
   logic        mask_nxt;
   logic        wr_pend_r;
   logic        wr_pend_nxt;
   logic [7:0]  wr_ofs_r;
   logic [7:0]  wr_ofs_nxt;
   logic [31:0] hrdata_r;
   logic [31:0] hrdata_nxt;
   logic [15:0] count_r;
   logic [15:0] count_nxt;
   logic [2:0]  presc_r;
   logic [2:0]  presc_nxt;
   logic [1:0]  instr_r;
   logic [1:0]  instr_nxt;
   logic        wake_r;
   logic        wake_nxt;

   logic        addr_phase;
   logic        wr_low;
   logic        wr_high;
   assign addr_phase = hsel && hready && htrans == gated_timer_pkg::HTRANS_NONSEQ;
   assign wr_low  = wr_pend_r && wr_ofs_r == gated_timer_pkg::COUNT_LOW_OFS;
   assign wr_high = wr_pend_r && wr_ofs_r == gated_timer_pkg::COUNT_HIGH_OFS;

   // control fields
   logic       run_bit;
   logic       unsync_bit;
   logic       gate_enable_bit;
   logic       gate_polarity_bit;
   logic [1:0] prescale_field;
   logic [1:0] clock_select_field;
   logic [1:0] gate_select_field;
   assign run_bit            = timer_ctrl_r[gated_timer_pkg::RUN_POS];
   assign unsync_bit         = timer_ctrl_r[gated_timer_pkg::UNSYNC_POS];
   assign prescale_field     = timer_ctrl_r[gated_timer_pkg::PRESC_LSB +: 2];
   assign clock_select_field = timer_ctrl_r[gated_timer_pkg::CSEL_LSB +: 2];
   assign gate_select_field  = gate_ctrl_r[gated_timer_pkg::GSEL_LSB +: 2];
   assign gate_polarity_bit  = gate_ctrl_r[gated_timer_pkg::GPOL_POS];
   assign gate_enable_bit    = gate_ctrl_r[gated_timer_pkg::GEN_POS];

   ////////////////////////////////////////////////////////////////////////////
   // clock source, gate and prescaler
   function automatic logic [7:0] prescale_mask(input logic [1:0] sel);
      case (sel)
         2'h0:    prescale_mask = 8'h00;
         2'h1:    prescale_mask = 8'h01;
         2'h2:    prescale_mask = 8'h03;
         default: prescale_mask = 8'h07;
      endcase
   endfunction

   logic ext_rise;
   logic temp_rise;
   logic src_tick;
   logic gate_raw;
   logic gate_active;
   logic count_en;
   logic presc_tick;
   logic overflow;
   // unsynchronised mode takes the edge from stage two, the same edge as synchronised mode
   assign ext_rise  = unsync_bit ? (pin_s2_r[0] && !ext_sync_d_r) : (ext_sync_d_r && !pin_s2_r[0] ? 1'b0
                      : pin_s2_r[0] && !ext_sync_d_r);
   assign temp_rise = pin_s2_r[1] && !temp_d_r;

   always_comb begin
      case (clock_select_field)
         gated_timer_pkg::CSEL_INSTR: src_tick = instr_r == gated_timer_pkg::INSTR_DIV;
         gated_timer_pkg::CSEL_SYS:   src_tick = 1'b1;
         gated_timer_pkg::CSEL_EXT:   src_tick = ext_rise;
         default:                     src_tick = temp_rise;
      endcase
      case (gate_select_field)
         2'h0:    gate_raw = pin_s2_r[2];
         2'h1:    gate_raw = timer0_overflow;
         2'h2:    gate_raw = pin_s2_r[3];
         default: gate_raw = pin_s2_r[4];
      endcase
   end

   assign gate_active = gate_raw ~^ gate_polarity_bit;
   assign count_en    = run_bit && (!gate_enable_bit || gate_active);
   assign presc_tick  = count_en && src_tick
                        && ({5'h00, presc_r} & prescale_mask(prescale_field)) == prescale_mask(prescale_field);
   assign overflow    = presc_tick && count_r == 16'hFFFF && !(wr_low || wr_high);

   always_comb begin
      instr_nxt = instr_r + 2'h1;
      presc_nxt = presc_r;
      count_nxt = count_r;
      if (count_en && src_tick)
         presc_nxt = presc_tick ? 3'h0 : presc_r + 3'h1;
      if (presc_tick)
         count_nxt = count_r + 16'h0001;
      if (wr_low) begin
         count_nxt[7:0] = hwdata[7:0];
         presc_nxt      = 3'h0;
      end
      if (wr_high) begin
         count_nxt[15:8] = hwdata[7:0];
         presc_nxt       = 3'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register file
   always_comb begin
      timer_ctrl_nxt = timer_ctrl_r;
      gate_ctrl_nxt  = gate_ctrl_r;
      mask_nxt       = mask_r;
      stat_nxt       = stat_r;
      wr_pend_nxt    = addr_phase && hwrite;
      wr_ofs_nxt     = addr_phase ? haddr[7:0] : wr_ofs_r;
      hrdata_nxt     = hrdata_r;
      wake_nxt       = wake_r;
      if (wr_pend_r) begin
         case (wr_ofs_r)
            gated_timer_pkg::TIMER_CTRL_OFS: timer_ctrl_nxt = hwdata[7:0];
            gated_timer_pkg::GATE_CTRL_OFS:  gate_ctrl_nxt  = hwdata[7:0];
            gated_timer_pkg::IRQ_MASK_OFS:   mask_nxt       = hwdata[gated_timer_pkg::OVF_POS];
            gated_timer_pkg::IRQ_STAT_OFS: begin
               if (hwdata[gated_timer_pkg::OVF_POS]) begin
                  stat_nxt = 1'b0;
                  wake_nxt = 1'b0;
               end
            end
            default: ;
         endcase
      end
      if (overflow) begin
         stat_nxt = 1'b1;
         if (clock_select_field == gated_timer_pkg::CSEL_EXT && unsync_bit && sleep_mode)
            wake_nxt = 1'b1;
      end
      if (addr_phase && !hwrite) begin
         case (haddr[7:0])
            gated_timer_pkg::COUNT_LOW_OFS:  hrdata_nxt = {24'h000000, count_r[7:0]};
            gated_timer_pkg::COUNT_HIGH_OFS: hrdata_nxt = {24'h000000, count_r[15:8]};
            gated_timer_pkg::TIMER_CTRL_OFS: hrdata_nxt = {24'h000000, timer_ctrl_r};
            gated_timer_pkg::GATE_CTRL_OFS:  hrdata_nxt = {24'h000000, gate_ctrl_r};
            gated_timer_pkg::IRQ_STAT_OFS:   hrdata_nxt = {31'h00000000, stat_r};
            gated_timer_pkg::IRQ_MASK_OFS:   hrdata_nxt = {31'h00000000, mask_r};
            default:                         hrdata_nxt = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         timer_ctrl_r <= gated_timer_pkg::TIMER_CTRL_RST;
         gate_ctrl_r  <= gated_timer_pkg::GATE_CTRL_RST;
         stat_r       <= 1'b0;
         mask_r       <= 1'b0;
         wr_pend_r    <= 1'b0;
         wr_ofs_r     <= 8'h00;
         hrdata_r     <= 32'h00000000;
         count_r      <= gated_timer_pkg::COUNT_RST;
         presc_r      <= 3'h0;
         instr_r      <= 2'h0;
         wake_r       <= 1'b0;
      end else begin
         timer_ctrl_r <= timer_ctrl_nxt;
         gate_ctrl_r  <= gate_ctrl_nxt;
         stat_r       <= stat_nxt;
         mask_r       <= mask_nxt;
         wr_pend_r    <= wr_pend_nxt;
         wr_ofs_r     <= wr_ofs_nxt;
         hrdata_r     <= hrdata_nxt;
         count_r      <= count_nxt;
         presc_r      <= presc_nxt;
         instr_r      <= instr_nxt;
         wake_r       <= wake_nxt;
      end
   end

   assign hrdata    = hrdata_r;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign time_base = count_r;
   assign wake_req  = wake_r;
   assign irq       = stat_r && mask_r;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   run_off_a: assert property (@(posedge clk) disable iff (rst)
      !run_bit && !wr_low && !wr_high |=> count_r == $past(count_r))
      else $error("counter moved while stopped");
   gate_hold_a: assert property (@(posedge clk) disable iff (rst)
      run_bit && gate_enable_bit && !gate_active && !wr_low && !wr_high |=> $stable(count_r))
      else $error("counter moved with gate inactive");
   sys_count_a: assert property (@(posedge clk) disable iff (rst)
      run_bit && !gate_enable_bit && clock_select_field == gated_timer_pkg::CSEL_SYS
      && prescale_field == 2'h0 && !wr_pend_r |=> count_r == $past(count_r) + 16'h0001)
      else $error("system clock count missed");
   low_write_a: assert property (@(posedge clk) disable iff (rst)
      wr_low |=> count_r[7:0] == $past(hwdata[7:0]))
      else $error("low byte write lost");
   high_write_a: assert property (@(posedge clk) disable iff (rst)
      wr_high |=> count_r[15:8] == $past(hwdata[7:0]) && presc_r == 3'h0)
      else $error("high byte write lost");
   ovf_flag_a: assert property (@(posedge clk) disable iff (rst)
      overflow |=> stat_r && count_r == 16'h0000)
      else $error("overflow flag not set");
   wake_cause_a: assert property (@(posedge clk) disable iff (rst)
      $rose(wake_r) |-> $past(clock_select_field) == gated_timer_pkg::CSEL_EXT && $past(unsync_bit))
      else $error("wake without async external clock");
   presc_div_a: assert property (@(posedge clk) disable iff (rst)
      presc_tick && prescale_field == 2'h3 |-> presc_r == 3'h7 ##1 presc_r == 3'h0)
      else $error("divide by eight out of step");

   // counting source, gate and prescaler checks
   instr_step_a: assert property (@(posedge clk) disable iff (rst)
      $changed(count_r) && !$past(wr_pend_r) && $past(clock_select_field) == gated_timer_pkg::CSEL_INSTR
      |-> $past(instr_r) == gated_timer_pkg::INSTR_DIV)
      else $error("instruction clock step off phase");
   ext_step_a: assert property (@(posedge clk) disable iff (rst)
      $changed(count_r) && !$past(wr_pend_r) && $past(clock_select_field) == gated_timer_pkg::CSEL_EXT
      |-> $past(ext_rise))
      else $error("external count without pin edge");
   temp_step_a: assert property (@(posedge clk) disable iff (rst)
      $changed(count_r) && !$past(wr_pend_r) && $past(clock_select_field) == gated_timer_pkg::CSEL_TEMP
      |-> $past(temp_rise))
      else $error("oscillator count without edge");
   no_enable_a: assert property (@(posedge clk) disable iff (rst)
      !count_en && !wr_low && !wr_high |=> $stable(count_r))
      else $error("counter moved while disabled");
   gate_pol_a: assert property (@(posedge clk) disable iff (rst)
      run_bit && gate_enable_bit && gate_raw != gate_polarity_bit |-> !count_en)
      else $error("inactive gate level counted");
   gate_src_a: assert property (@(posedge clk) disable iff (rst)
      gate_select_field == 2'h1 |-> gate_raw == timer0_overflow)
      else $error("gate source select wrong");
   write_presc_a: assert property (@(posedge clk) disable iff (rst)
      wr_low || wr_high |=> presc_r == 3'h0)
      else $error("prescaler not cleared by write");
   div_two_a: assert property (@(posedge clk) disable iff (rst)
      count_en && src_tick && prescale_field == 2'h1 && presc_r == 3'h1 && !wr_low && !wr_high
      |=> count_r == $past(count_r) + 16'h0001)
      else $error("divide by two step missed");

   // bus and flag checks
   read_low_a: assert property (@(posedge clk) disable iff (rst)
      addr_phase && !hwrite && haddr[7:0] == gated_timer_pkg::COUNT_LOW_OFS
      |=> hrdata == {24'h000000, $past(count_r[7:0])})
      else $error("low byte read wrong");
   read_high_a: assert property (@(posedge clk) disable iff (rst)
      addr_phase && !hwrite && haddr[7:0] == gated_timer_pkg::COUNT_HIGH_OFS
      |=> hrdata == {24'h000000, $past(count_r[15:8])})
      else $error("high byte read wrong");
   bus_okay_a: assert property (@(posedge clk) disable iff (rst)
      hreadyout && !hresp)
      else $error("bus answer not okay");
   stat_rise_a: assert property (@(posedge clk) disable iff (rst)
      $rose(stat_r) |-> $past(overflow))
      else $error("flag set without overflow");
   stat_hold_a: assert property (@(posedge clk) disable iff (rst)
      stat_r && !(wr_pend_r && wr_ofs_r == gated_timer_pkg::IRQ_STAT_OFS && hwdata[gated_timer_pkg::OVF_POS])
      |=> stat_r)
      else $error("flag cleared without software");
   wake_hold_a: assert property (@(posedge clk) disable iff (rst)
      wake_r && !(wr_pend_r && wr_ofs_r == gated_timer_pkg::IRQ_STAT_OFS && hwdata[gated_timer_pkg::OVF_POS])
      |=> wake_r)
      else $error("wake dropped without software");
   write_wins_a: assert property (@(posedge clk) disable iff (rst)
      presc_tick && count_r == 16'hFFFF && (wr_low || wr_high) && !stat_r |=> !stat_r)
      else $error("flag set despite count write");
   base_out_a: assert property (@(posedge clk) disable iff (rst)
      time_base == count_r && irq == (stat_r && mask_r))
      else $error("time base or irq mismatch");

endmodule

`default_nettype wire

// ### hw/gated_timer_pkg.sv
/*
 * constants, register map and field layout of the gated sixteen-bit timer.
 * assumes a 32-bit ahb-lite register bus and a 20 MHz core clock.
 */
package gated_timer_pkg;

   localparam logic [7:0] COUNT_LOW_OFS  = 8'h00;
   localparam logic [7:0] COUNT_HIGH_OFS = 8'h04;
   localparam logic [7:0] TIMER_CTRL_OFS = 8'h08;
   localparam logic [7:0] GATE_CTRL_OFS  = 8'h0C;
   localparam logic [7:0] IRQ_STAT_OFS   = 8'h10;
   localparam logic [7:0] IRQ_MASK_OFS   = 8'h14;

   // timer control fields
   localparam int RUN_POS    = 0;
   localparam int UNSYNC_POS = 2;
   localparam int PRESC_LSB  = 4;
   localparam int CSEL_LSB   = 6;
   // gate control fields
   localparam int GSEL_LSB   = 0;
   localparam int GPOL_POS   = 6;
   localparam int GEN_POS    = 7;
   // status / mask bits
   localparam int OVF_POS    = 0;

   localparam logic [7:0]  TIMER_CTRL_RST = 8'h00;
   localparam logic [7:0]  GATE_CTRL_RST  = 8'h00;
   localparam logic [15:0] COUNT_RST      = 16'h0000;
   localparam logic [1:0]  INSTR_DIV      = 2'h3;

   localparam logic [1:0] CSEL_INSTR = 2'h0;
   localparam logic [1:0] CSEL_SYS   = 2'h1;
   localparam logic [1:0] CSEL_EXT   = 2'h2;
   localparam logic [1:0] CSEL_TEMP  = 2'h3;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// ### bench/ext_source_model.sv
/*
 * far-side model: external clock pin bursts and a free-running temperature oscillator.
 * assumes start is held high by the bench until busy rises; pin rests low between bursts.
 */
`timescale 1ns/1ns
`default_nettype none
module ext_source_model (
   input  wire logic       clk,
   input  wire logic       start,
   input  wire logic [3:0] pulses,
   input  wire logic [4:0] half_len,
   output logic            pin,
   output logic            temp_osc,
   output logic            busy
);
   ////////////////////////////////////////////////////////////
   initial begin
      pin = 1'b0;
      temp_osc = 1'b0;
      busy = 1'b0;
   end

   // oscillator keeps running, slower than clk so the synchroniser sees each edge
   always #175 temp_osc = ~temp_osc;

   always @(posedge clk) begin
      if (start) begin
         busy <= 1'b1;
         for (int i = 0; i < pulses; i++) begin
            pin <= 1'b1;
            repeat (half_len) @(posedge clk);
            pin <= 1'b0;
            repeat (half_len) @(posedge clk);
         end
         busy <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ### bench/tb.sv
/*
 * self-checking bench for the gated sixteen-bit timer over ahb-lite.
 * assumes zero-wait-state slave answers and the source model on the pins.
 */
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic        clk, rst, hsel, hwrite, start, gate_input, timer0_overflow, comp1_out, comp2_out, sleep_mode;
   logic        hreadyout, hresp, wake_req, irq, pin, tosc, busy;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [3:0]  pulses, srcs;
   logic [4:0]  half_len;
   logic [15:0] time_base, v;
   logic [31:0] haddr, hwdata, hrdata, d;
   int          error_cnt, samples_checked;

   gated_timer gated_timer_inst (
      .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .external_clock_pin(pin), .temp_osc_clk(tosc), .gate_input(gate_input),
      .timer0_overflow(timer0_overflow), .comp1_out(comp1_out), .comp2_out(comp2_out),
      .sleep_mode(sleep_mode), .time_base(time_base), .wake_req(wake_req), .irq(irq));
   ext_source_model ext_source_model_inst (.clk(clk), .start(start), .pulses(pulses),
      .half_len(half_len), .pin(pin), .temp_osc(tosc), .busy(busy));

   always #25 clk = ~clk;

   ////////////////////////////////////////////////////////////
   task conclude;
      $display("mismatches %0d of %0d comparisons", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task check(input string nm, input logic [31:0] e, input logic [31:0] s);
      samples_checked++;
      if (s !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task check_rng(input string nm, input int lo, input int hi, input logic [15:0] s);
      samples_checked++;
      if ($isunknown(s) || s < lo || s > hi) begin
         error_cnt++;
         $display("[FAIL] %s expected %0d..%0d seen %h", nm, lo, hi, s);
      end
   endtask
   task wait_rdy;
      int k;
      k = 0;
      @(posedge clk);
      while (hreadyout !== 1'b1 && k < 50) begin
         k++;
         @(posedge clk);
      end
      if (k >= 50) begin
         error_cnt++;
         conclude;
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] dat);
      haddr <= {24'h000000, a};
      htrans <= gated_timer_pkg::HTRANS_NONSEQ;
      hwrite <= 1'b1;
      wait_rdy;
      htrans <= 2'h0;
      hwdata <= dat;
      wait_rdy;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] o);
      haddr <= {24'h000000, a};
      htrans <= gated_timer_pkg::HTRANS_NONSEQ;
      hwrite <= 1'b0;
      wait_rdy;
      htrans <= 2'h0;
      wait_rdy;
      o = hrdata;
   endtask
   task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      rd(a, r);
      check(nm, e, r);
   endtask
   // outputs sampled mid-cycle, away from the edge that updates them
   task outs(output logic [31:0] o);
      @(negedge clk);
      o = {13'h0000, hresp, wake_req, irq, time_base};
      @(posedge clk);
   endtask
   function automatic logic [31:0] ctl(input logic r, input logic u, input logic [1:0] p, input logic [1:0] c);
      return ({31'h0, r} << gated_timer_pkg::RUN_POS) | ({31'h0, u} << gated_timer_pkg::UNSYNC_POS)
         | ({30'h0, p} << gated_timer_pkg::PRESC_LSB) | ({30'h0, c} << gated_timer_pkg::CSEL_LSB);
   endfunction
   // load count, run with control c, stop and read the count back into v
   task run(input logic [31:0] c, input logic [15:0] s, input int cyc, input logic [3:0] np, input logic [4:0] h);
      int k;
      wr(gated_timer_pkg::COUNT_LOW_OFS, {24'h000000, s[7:0]});
      wr(gated_timer_pkg::COUNT_HIGH_OFS, {24'h000000, s[15:8]});
      wr(gated_timer_pkg::TIMER_CTRL_OFS, c);
      pulses <= np;
      half_len <= h;
      start <= (np != 4'h0);
      repeat (cyc) @(posedge clk);
      start <= 1'b0;
      k = 0;
      while (busy === 1'b1 && k < 400) begin
         k++;
         @(posedge clk);
      end
      if (k >= 400) begin
         error_cnt++;
         conclude;
      end
      repeat (6) @(posedge clk);
      wr(gated_timer_pkg::TIMER_CTRL_OFS, c & 32'hFFFFFFFE);
      rd(gated_timer_pkg::COUNT_LOW_OFS, d);
      v[7:0] = d[7:0];
      rd(gated_timer_pkg::COUNT_HIGH_OFS, d);
      v[15:8] = d[7:0];
      check("count_readback", {16'h0, time_base}, {16'h0, v});
      check("bus_resp", 32'h0, {31'h0, hresp});
   endtask

   ////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      hsel = 1'b1;
      hwrite = 1'b0;
      start = 1'b0;
      {comp2_out, comp1_out, timer0_overflow, gate_input} = 4'h0;
      sleep_mode = 1'b0;
      htrans = 2'h0;
      hsize = 3'h2;
      pulses = 4'h0;
      half_len = 5'h02;
      haddr = 32'h0;
      hwdata = 32'h0;
      error_cnt = 0;
      samples_checked = 0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      wr(8'h18, 32'hFFFFFFFF);
      for (int a = 0; a <= 24; a += 4) rchk("reset_reg", 8'(a), 32'h0);
      outs(d);
      check("outputs", 32'h0, d);
      wr(gated_timer_pkg::TIMER_CTRL_OFS, 32'hF5);
      wr(gated_timer_pkg::GATE_CTRL_OFS, 32'hC3);
      rchk("timer_ctrl", gated_timer_pkg::TIMER_CTRL_OFS, 32'hF5);
      rchk("gate_ctrl", gated_timer_pkg::GATE_CTRL_OFS, 32'hC3);
      wr(gated_timer_pkg::GATE_CTRL_OFS, 32'h80);
      run(ctl(0, 0, 0, gated_timer_pkg::CSEL_SYS), 16'h1234, 20, 4'h0, 5'h00);
      check("held", 32'h1234, {16'h0, v});
      wr(gated_timer_pkg::COUNT_LOW_OFS, 32'hAB);
      outs(d);
      check("time_base", 32'h12AB, d);
      wr(gated_timer_pkg::GATE_CTRL_OFS, 32'h00);
      for (int c = 0; c < 2; c++) begin
         for (int p = 0; p < 4; p++) begin
            run(ctl(1, 0, 2'(p), 2'(c)), 16'h0000, 120, 4'h0, 5'h00);
            check_rng("rate", (126 >> (p + 2 - 2 * c)) - 1, (130 >> (p + 2 - 2 * c)) + 1, v);
         end
      end
      run(ctl(1, 0, 0, gated_timer_pkg::CSEL_TEMP), 16'h0000, 120, 4'h0, 5'h00);
      check_rng("temp_osc", 16, 20, v);
      run(ctl(1, 0, 0, gated_timer_pkg::CSEL_EXT), 16'h0100, 3, 4'h5, 5'h02);
      check("ext_fast", 32'h0105, {16'h0, v});
      run(ctl(1, 0, 0, gated_timer_pkg::CSEL_EXT), 16'h0100, 3, 4'h5, 5'h09);
      check("ext_slow", 32'h0105, {16'h0, v});
      run(ctl(1, 0, 1, gated_timer_pkg::CSEL_EXT), 16'h0000, 3, 4'h6, 5'h02);
      check("ext_div2", 32'h0003, {16'h0, v});
      for (int pol = 0; pol < 2; pol++) begin
         for (int s = 0; s < 4; s++) begin
            srcs = (pol == 1) ? (4'h1 << s) : ~(4'h1 << s);
            {comp2_out, comp1_out, timer0_overflow, gate_input} <= srcs;
            wr(gated_timer_pkg::GATE_CTRL_OFS, {24'h0, 1'b1, 1'(pol), 4'h0, 2'(s)});
            run(ctl(1, 0, 0, gated_timer_pkg::CSEL_SYS), 16'h0000, 40, 4'h0, 5'h00);
            check_rng("gate_open", 45, 51, v);
            {comp2_out, comp1_out, timer0_overflow, gate_input} <= ~srcs;
            run(ctl(1, 0, 0, gated_timer_pkg::CSEL_SYS), 16'h0000, 40, 4'h0, 5'h00);
            check_rng("gate_shut", 0, 0, v);
         end
      end
      wr(gated_timer_pkg::GATE_CTRL_OFS, 32'h00);
      sleep_mode <= 1'b1;
      run(ctl(1, 0, 0, gated_timer_pkg::CSEL_SYS), 16'hFFFE, 2, 4'h0, 5'h00);
      check_rng("wrapped", 6, 12, v);
      rchk("ovf_set", gated_timer_pkg::IRQ_STAT_OFS, 32'h1);
      outs(d);
      check("masked", 32'h0, {30'h0, d[17:16]});
      wr(gated_timer_pkg::IRQ_MASK_OFS, 32'h1);
      outs(d);
      check("irq_on", 32'h1, {30'h0, d[17:16]});
      wr(gated_timer_pkg::IRQ_STAT_OFS, 32'h1);
      rchk("ovf_clr", gated_timer_pkg::IRQ_STAT_OFS, 32'h0);
      for (int u = 0; u < 2; u++) begin
         run(ctl(1, 1'(u), 0, gated_timer_pkg::CSEL_EXT), 16'hFFFF, 3, 4'h2, 5'h03);
         check("ext_wrap", 32'h0001, {16'h0, v});
         outs(d);
         check("wake", {30'h0, 1'(u), 1'b1}, {30'h0, d[17:16]});
         wr(gated_timer_pkg::IRQ_STAT_OFS, 32'h1);
         outs(d);
         check("wake_clr", 32'h0, {30'h0, d[17:16]});
      end
      conclude;
   end
endmodule
`default_nettype wire
